// *** core/bxf_pkg.sv ***
// Constants, state enumeration and register map of the bisync / X.21 channel framer.
// Assumes a single 20 MHz core clock and an AXI4-Lite master for software access.
//
// Overview of operation
// - Cyclic check is CRC-16, polynomial x16+x15+x2+1, preset to all zeros.
// - Option register 2 bit 7 set selects longitudinal check, clear selects CRC-16.
// - Longitudinal check is even parity per bit position over included characters.
// - With character parity on, the parity bit position is left out of the check.
// - Transparent receive excludes escaping DLE; escaped SYN excludes both characters.
// - Transparent receive strips escaping DLE from delivered data, check still verified.
// - After previous DLE-ITB the check starts right after the opening SYN pair.
// - Otherwise opening SYNs and leading SOH, STX or DLE-STX are excluded.
// - Embedded SYNs in a non-transparent frame are skipped by the check.
// - Non-transparent frame check ends including ETX, ETB or ITB; two check bytes follow.
// - Sync hunt uses two substates to find SYN-SYN, then enters header wait.
// - Receive states 2 to 9: header, first escape, later escape, text, chk1, chk2, pad, transparent.
// - After second check byte go to header wait if intermediate flag set, else hunt.
// - STX in header wait initializes check, enters text, accumulated only if flag set.
// - ITB from text or later escape sets flag; ETX or ETB clears it; accumulated.
// - Extra termination transitions apply only when termination register is not hex 10.
// - Flag cleared on return to hunt; pad wait holds until PAD arrives.
// - Transparent state accumulates and moves to later escape on DLE.
// - Transmit byte 80 hex starts four-byte command: C lead, raw character, repeat count.
// - Repeat count zero repeats until new data, always at least three times.
// - Steady state valid after two character times with stable clear-to-send; changes only.
// - SYN strip and special detect act only while steady-state detection is enabled.
// - With strip on, two valid SYNs raise special event and later SYNs drop.
// - Special character seen twice after sync raises event; repeats stripped until change.
// - Partial characters and data before sync are delivered as normal data.
// - After reset receiver starts in sync hunt, discarding data until SYN pair.
// - Extra termination character ends frame at once without check; reset loads hex 10.
package bxf_pkg;
   localparam logic [7:0] SYN_C = 8'h32;
   localparam logic [7:0] DLE_C = 8'h10;
   localparam logic [7:0] ENQ_C = 8'h2d;
   localparam logic [7:0] STX_C = 8'h02;
   localparam logic [7:0] SOH_C = 8'h01;
   localparam logic [7:0] EOT_C = 8'h37;
   localparam logic [7:0] ETX_C = 8'h03;
   localparam logic [7:0] ETB_C = 8'h26;
   localparam logic [7:0] ITB_C = 8'h1f;
   localparam logic [7:0] PAD_C = 8'hff;
   localparam logic [7:0] ETC_START = 8'h80;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam int unsigned ETC_MIN_REP = 3;
   localparam int unsigned SS_CHARS = 2;
   // Register byte offsets
   localparam logic [7:0] OPT2_OFS = 8'h00;
   localparam logic [7:0] OPT3_OFS = 8'h04;
   localparam logic [7:0] TERM_OFS = 8'h08;
   localparam logic [7:0] SCHR_OFS = 8'h0c;
   localparam logic [7:0] STAT_OFS = 8'h10;
   localparam logic [7:0] TXD_OFS  = 8'h14;
   localparam logic [7:0] RXD_OFS  = 8'h18;
   localparam logic [7:0] CHK_OFS  = 8'h1c;
   // Option register 2 fields
   localparam int unsigned OPT2_LRC = 7;
   localparam int unsigned OPT2_ETC = 5;
   localparam int unsigned OPT2_PAR = 0;
   // Option register 3 fields
   localparam int unsigned OPT3_SGL  = 7;
   localparam int unsigned OPT3_STEADY_STATE_DETECT_ENABLE = 6;
   localparam int unsigned OPT3_STRP = 5;
   localparam int unsigned OPT3_SPECIAL_CHAR_DETECT_ENABLE = 4;
   localparam int unsigned OPT3_X21  = 0;
   localparam logic [7:0] OPT2_RST = 8'h00;
   localparam logic [7:0] OPT3_RST = 8'h00;
   localparam logic [7:0] TERM_RST = 8'h10;
   localparam logic [23:0] SCHR_RST = 24'h000000;
   typedef enum logic [3:0] {
      BXF_HUNT1, BXF_HUNT2,
      BXF_HDR, BXF_ESCF, BXF_ESCL, BXF_TXT, BXF_BCC1, BXF_BCC2, BXF_PADW, BXF_XP
   } bxf_rx_st_t;
endpackage

// *** core/bxf_bcc.sv ***
// Block check accumulator: CRC-16 or longitudinal parity over one character per step.
// Assumes the caller presents init and step strobes on the core clock.
`timescale 1ns/100ps
module bxf_bcc (
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_init,
   input  wire logic        i_step,
   input  wire logic        i_lrc,
   input  wire logic        i_par,
   input  wire logic [7:0]  i_char,
   output logic      [15:0] o_bcc
);
   logic [15:0] bcc_q;
   logic [15:0] base;
   logic [15:0] crc;
   logic [7:0]  ch;
   always_comb begin
      base = i_init ? bxf_pkg::CRC_INIT : bcc_q;
      ch = i_par ? {1'b0, i_char[6:0]} : i_char;
      crc = base;
      for (int k = 0; k < 8; k++) begin
         if (crc[15] ^ ch[k]) begin
            crc = {crc[14:0], 1'b0} ^ bxf_pkg::CRC_POLY;
         end else begin
            crc = {crc[14:0], 1'b0};
         end
      end
   end
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bcc_q <= bxf_pkg::CRC_INIT;
      end else if (i_step) begin
         bcc_q <= i_lrc ? {8'h00, base[7:0] ^ ch} : crc;
      end else if (i_init) begin
         bcc_q <= bxf_pkg::CRC_INIT;
      end
   end
   assign o_bcc = bcc_q;
endmodule

// *** core/bxf_framer.sv ***
// Bisync / X.21 channel framer: receive state machine, block check, X.21 steady
// state validation and embedded transmit command, with an AXI4-Lite register port.
// Assumes serial bit timing is done elsewhere: characters arrive as strobes.
`timescale 1ns/100ps
module bxf_framer (
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   input  wire logic        i_rx_stb,
   input  wire logic [7:0]  i_rx_char,
   input  wire logic        i_cts_n,
   input  wire logic        i_tx_req,
   output logic [7:0]       o_tx_char,
   output logic             o_tx_raw,
   output logic             o_c_lead,
   output logic             o_rx_valid,
   output logic [7:0]       o_rx_data
);
   logic [7:0]  opt2_q, opt3_q, term_q, txd_q;
   logic [23:0] schr_q;
   logic        txd_full_q;
   logic [7:0]  rxd_q;
   logic [7:0]  stat_q;
   logic        aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [1:0]  cts_s_q;
   logic [1:0]  stb_s_q;
   logic [15:0] chr_s_q;
   logic [15:0] bcc;
   logic        stb_d1_q;
   logic        rx_ev;
   logic        wr_go, rd_go;
   function automatic logic ok_addr(input logic [7:0] a);
      ok_addr = (a[1:0] == 2'b00) && (a <= bxf_pkg::CHK_OFS);
   endfunction

   // AXI4-Lite slave: address and data captured in either order
   assign wr_go = aw_q && w_q && !bvalid_q;
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
      end else begin
         if (i_awvalid && !aw_q) begin
            aw_q <= 1'b1;
            o_awready <= 1'b0;
            awaddr_q <= i_awaddr;
         end
         if (i_wvalid && !w_q) begin
            w_q <= 1'b1;
            o_wready <= 1'b0;
            wdata_q <= i_wstrb[0] ? i_wdata : 32'h00000000;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            bvalid_q <= 1'b1;
            bresp_q <= ok_addr(awaddr_q) ? 2'b00 : 2'b10;
         end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   assign o_bvalid = bvalid_q;
   assign o_bresp = bresp_q;

   assign rd_go = i_arvalid && !rvalid_q;
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rvalid_q <= 1'b0;
         o_arready <= 1'b1;
         rdata_q <= 32'h00000000;
         rresp_q <= 2'b00;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         o_arready <= 1'b0;
         rresp_q <= ok_addr(i_araddr) ? 2'b00 : 2'b10;
         case (i_araddr)
            bxf_pkg::OPT2_OFS: rdata_q <= {24'h000000, opt2_q};
            bxf_pkg::OPT3_OFS: rdata_q <= {24'h000000, opt3_q};
            bxf_pkg::TERM_OFS: rdata_q <= {24'h000000, term_q};
            bxf_pkg::SCHR_OFS: rdata_q <= {8'h00, schr_q};
            bxf_pkg::STAT_OFS: rdata_q <= {24'h000000, stat_q};
            bxf_pkg::TXD_OFS:  rdata_q <= {23'h000000, txd_full_q, txd_q};
            bxf_pkg::RXD_OFS:  rdata_q <= {24'h000000, rxd_q};
            bxf_pkg::CHK_OFS:  rdata_q <= {16'h0000, bcc};
            default:           rdata_q <= 32'h00000000;
         endcase
      end else if (rvalid_q && i_rready) begin
         rvalid_q <= 1'b0;
         o_arready <= 1'b1;
      end
   end
   assign o_rvalid = rvalid_q;
   assign o_rdata = rdata_q;
   assign o_rresp = rresp_q;

   logic tx_take;
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         opt2_q <= bxf_pkg::OPT2_RST;
         opt3_q <= bxf_pkg::OPT3_RST;
         term_q <= bxf_pkg::TERM_RST;
         schr_q <= bxf_pkg::SCHR_RST;
         txd_q <= 8'h00;
         txd_full_q <= 1'b0;
      end else begin
         if (tx_take) begin
            txd_full_q <= 1'b0;
         end
         if (wr_go && awaddr_q == bxf_pkg::OPT2_OFS) opt2_q <= wdata_q[7:0];
         if (wr_go && awaddr_q == bxf_pkg::OPT3_OFS) opt3_q <= wdata_q[7:0];
         if (wr_go && awaddr_q == bxf_pkg::TERM_OFS) term_q <= wdata_q[7:0];
         if (wr_go && awaddr_q == bxf_pkg::SCHR_OFS) schr_q <= wdata_q[23:0];
         if (wr_go && awaddr_q == bxf_pkg::TXD_OFS && !txd_full_q) begin
            txd_q <= wdata_q[7:0];
            txd_full_q <= 1'b1;
         end
      end
   end

   // Pin-level CTS, strobe and character pass two flops before use; transmit request is used directly
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cts_s_q <= 2'b00;
         stb_s_q <= 2'b00;
         chr_s_q <= 16'h0000;
         stb_d1_q <= 1'b0;
      end else begin
         cts_s_q <= {cts_s_q[0], i_cts_n};
         stb_s_q <= {stb_s_q[0], i_rx_stb};
         stb_d1_q <= stb_s_q[1];
         // Character takes the same two flops; it is held around its strobe
         chr_s_q <= {chr_s_q[7:0], i_rx_char};
      end
   end
   assign rx_ev = stb_s_q[1] && !stb_d1_q;

   // Bisync receive
   bxf_pkg::bxf_rx_st_t st_q, st_d;
   logic       itb_q, itb_d;
   logic       init, step, deliver, x21, term_act;
   logic       fin_q, crc_err_q, abort_q;
   logic [7:0] c, bcc1_q;
   logic       fin_d, err_d, abt_d;
   assign c = chr_s_q[15:8];
   assign x21 = opt3_q[bxf_pkg::OPT3_X21];
   assign term_act = term_q != bxf_pkg::DLE_C;

   always_comb begin
      st_d = st_q;
      itb_d = itb_q;
      init = 1'b0;
      step = 1'b0;
      deliver = 1'b0;
      fin_d = 1'b0;
      err_d = 1'b0;
      abt_d = 1'b0;
      case (st_q)
         bxf_pkg::BXF_HUNT1: if (c == bxf_pkg::SYN_C) st_d = bxf_pkg::BXF_HUNT2;
         bxf_pkg::BXF_HUNT2: st_d = (c == bxf_pkg::SYN_C) ? bxf_pkg::BXF_HDR : bxf_pkg::BXF_HUNT1;
         bxf_pkg::BXF_HDR: begin
            deliver = c != bxf_pkg::SYN_C;
            if (c == bxf_pkg::SYN_C) st_d = bxf_pkg::BXF_HDR;
            else if (c == bxf_pkg::DLE_C) begin
               init = 1'b1;
               st_d = itb_q ? bxf_pkg::BXF_ESCL : bxf_pkg::BXF_ESCF;
               step = itb_q;
               deliver = 1'b0;
            end else if (c == bxf_pkg::STX_C || c == bxf_pkg::SOH_C) begin
               init = 1'b1;
               step = itb_q;
               st_d = bxf_pkg::BXF_TXT;
            end else if ((c == bxf_pkg::ENQ_C || c == bxf_pkg::ETX_C ||
                          c == bxf_pkg::ETB_C) && itb_q) begin
               st_d = bxf_pkg::BXF_HUNT1;
               abt_d = c == bxf_pkg::ENQ_C;
            end else if (itb_q) begin
               init = 1'b1;
               step = 1'b1;
               st_d = bxf_pkg::BXF_TXT;
            end else st_d = bxf_pkg::BXF_PADW;
         end
         bxf_pkg::BXF_ESCF, bxf_pkg::BXF_ESCL: begin
            deliver = c != bxf_pkg::SYN_C;
            if (c == bxf_pkg::SYN_C) st_d = bxf_pkg::BXF_XP;
            else if (c == bxf_pkg::STX_C || c == bxf_pkg::SOH_C) begin
               init = st_q == bxf_pkg::BXF_ESCF;
               step = st_q == bxf_pkg::BXF_ESCL;
               st_d = bxf_pkg::BXF_XP;
            end else if (c == bxf_pkg::ITB_C || ((c == bxf_pkg::ETX_C ||
                         c == bxf_pkg::ETB_C) && st_q == bxf_pkg::BXF_ESCL)) begin
               step = 1'b1;
               itb_d = c == bxf_pkg::ITB_C;
               st_d = (st_q == bxf_pkg::BXF_ESCL) ? bxf_pkg::BXF_BCC1 : bxf_pkg::BXF_PADW;
            end else if (st_q == bxf_pkg::BXF_ESCL) begin
               step = 1'b1;
               st_d = bxf_pkg::BXF_XP;
            end else if (c == bxf_pkg::ENQ_C || c == bxf_pkg::EOT_C) begin
               st_d = bxf_pkg::BXF_HUNT1;
               abt_d = 1'b1;
            end else st_d = bxf_pkg::BXF_PADW;
         end
         bxf_pkg::BXF_TXT: begin
            deliver = c != bxf_pkg::SYN_C;
            if (c == bxf_pkg::SYN_C) st_d = bxf_pkg::BXF_TXT;
            else if (c == bxf_pkg::DLE_C) begin
               step = 1'b1;
               st_d = bxf_pkg::BXF_ESCL;
            end else if (c == bxf_pkg::ITB_C || c == bxf_pkg::ETX_C || c == bxf_pkg::ETB_C) begin
               step = 1'b1;
               itb_d = c == bxf_pkg::ITB_C;
               st_d = bxf_pkg::BXF_BCC1;
            end else if (c == bxf_pkg::ENQ_C || c == bxf_pkg::EOT_C) begin
               st_d = bxf_pkg::BXF_HUNT1;
               abt_d = c == bxf_pkg::ENQ_C;
            end else if (term_act && c == term_q) begin
               st_d = bxf_pkg::BXF_HUNT1;
               fin_d = 1'b1;
            end else step = 1'b1;
         end
         bxf_pkg::BXF_XP: begin
            deliver = c != bxf_pkg::DLE_C;
            if (c == bxf_pkg::DLE_C) st_d = bxf_pkg::BXF_ESCL;
            else if (term_act && c == term_q) begin
               st_d = bxf_pkg::BXF_HUNT1;
               fin_d = 1'b1;
            end else step = 1'b1;
         end
         bxf_pkg::BXF_BCC1: st_d = bxf_pkg::BXF_BCC2;
         bxf_pkg::BXF_BCC2: begin
            st_d = itb_q ? bxf_pkg::BXF_HDR : bxf_pkg::BXF_HUNT1;
            fin_d = 1'b1;
            err_d = opt2_q[bxf_pkg::OPT2_LRC] ? (bcc1_q != bcc[7:0]) :
                    ({bcc1_q, c} != bcc);
         end
         bxf_pkg::BXF_PADW: if (c == bxf_pkg::PAD_C) st_d = bxf_pkg::BXF_HUNT1;
         default: st_d = bxf_pkg::BXF_HUNT1;
      endcase
      if (st_d == bxf_pkg::BXF_HUNT1) itb_d = 1'b0;
   end

   bxf_bcc u_bcc (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_init     (rx_ev && !x21 && init),
      .i_step     (rx_ev && !x21 && step),
      .i_lrc      (opt2_q[bxf_pkg::OPT2_LRC]),
      .i_par      (opt2_q[bxf_pkg::OPT2_PAR]),
      .i_char     (c),
      .o_bcc      (bcc)
   );

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_q <= bxf_pkg::BXF_HUNT1;
         itb_q <= 1'b0;
         bcc1_q <= 8'h00;
      end else if (rx_ev && !x21) begin
         st_q <= st_d;
         itb_q <= itb_d;
         if (st_q == bxf_pkg::BXF_BCC1) bcc1_q <= c;
      end
   end

   // X.21 steady state: same character twice with unchanged CTS
   logic [7:0] last_q;
   logic       last_cts_q, sync_q, same;
   logic [1:0] cnt_q;
   logic       ss_ev, is_ss, is_sp, is_syn, strip, steady_state_detect_enable;
   assign steady_state_detect_enable = opt3_q[bxf_pkg::OPT3_STEADY_STATE_DETECT_ENABLE];
   assign same = c == last_q && cts_s_q[1] == last_cts_q;
   assign is_syn = c == bxf_pkg::SYN_C;
   assign is_sp = sync_q && (c == schr_q[7:0] || c == schr_q[15:8] || c == schr_q[23:16]);
   assign is_ss = steady_state_detect_enable && (c == 8'hff || c == 8'h00 || c == 8'h55 || c == 8'haa ||
                  (is_syn && opt3_q[bxf_pkg::OPT3_STRP]) ||
                  (is_sp && opt3_q[bxf_pkg::OPT3_SPECIAL_CHAR_DETECT_ENABLE]));
   // Fires once per run of equal characters, so all-zero steady state reports too
   assign ss_ev = is_ss && same && cnt_q == 2'(bxf_pkg::SS_CHARS - 2);
   assign strip = is_ss && same && cnt_q >= 2'(bxf_pkg::SS_CHARS - 1) &&
                  (is_syn || is_sp);
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         last_q <= 8'h00;
         last_cts_q <= 1'b1;
         cnt_q <= 2'b00;
         sync_q <= 1'b0;
      end else if (rx_ev && x21) begin
         last_q <= c;
         last_cts_q <= cts_s_q[1];
         cnt_q <= same ? ((cnt_q == 2'b11) ? cnt_q : cnt_q + 2'b01) : 2'b00;
         if (is_syn && same) sync_q <= 1'b1;
      end
   end

   // Delivered data and status; set wins over software read-clear
   logic rd_stat;
   assign rd_stat = rd_go && i_araddr == bxf_pkg::STAT_OFS;
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rx_valid <= 1'b0;
         o_rx_data <= 8'h00;
         rxd_q <= 8'h00;
         stat_q <= 8'h00;
      end else begin
         o_rx_valid <= rx_ev && (x21 ? !strip : deliver);
         if (rx_ev) o_rx_data <= c;
         if (rx_ev && (x21 ? !strip : deliver)) rxd_q <= c;
         stat_q <= (rd_stat ? 8'h00 : stat_q) |
                   {4'h0, rx_ev && x21 && ss_ev, rx_ev && !x21 && abt_d,
                    rx_ev && !x21 && err_d, rx_ev && !x21 && fin_d};
      end
   end

   // Embedded transmit command
   logic [1:0] etc_ph_q;
   logic [7:0] rep_chr_q, rep_cnt_q;
   logic       rep_on_q, inf_q;
   logic [1:0] min_q;
   assign tx_take = i_tx_req && txd_full_q && !(rep_on_q &&
                    (!inf_q || min_q != 2'(bxf_pkg::ETC_MIN_REP)));
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         etc_ph_q <= 2'b00;
         rep_chr_q <= 8'h00;
         rep_cnt_q <= 8'h00;
         rep_on_q <= 1'b0;
         inf_q <= 1'b0;
         min_q <= 2'b00;
         o_c_lead <= 1'b0;
         o_tx_char <= bxf_pkg::SYN_C;
         o_tx_raw <= 1'b0;
      end else if (i_tx_req) begin
         if (tx_take) begin
            rep_on_q <= 1'b0;
            o_tx_raw <= 1'b0;
            if (etc_ph_q == 2'b00 && opt2_q[bxf_pkg::OPT2_ETC] &&
                txd_q == bxf_pkg::ETC_START) etc_ph_q <= 2'b01;
            else if (etc_ph_q == 2'b01) begin
               if (txd_q == 8'h00) o_c_lead <= 1'b0;
               if (txd_q == 8'h01) o_c_lead <= 1'b1;
               etc_ph_q <= 2'b10;
            end else if (etc_ph_q == 2'b10) begin
               rep_chr_q <= txd_q;
               etc_ph_q <= 2'b11;
            end else if (etc_ph_q == 2'b11) begin
               rep_cnt_q <= txd_q;
               inf_q <= txd_q == 8'h00;
               min_q <= 2'b00;
               rep_on_q <= 1'b1;
               etc_ph_q <= 2'b00;
            end else o_tx_char <= txd_q;
            if (etc_ph_q != 2'b00 || (opt2_q[bxf_pkg::OPT2_ETC] &&
                txd_q == bxf_pkg::ETC_START)) o_tx_char <= bxf_pkg::SYN_C;
         end else if (rep_on_q) begin
            o_tx_char <= rep_chr_q;
            o_tx_raw <= 1'b1;
            if (min_q != 2'(bxf_pkg::ETC_MIN_REP)) min_q <= min_q + 2'b01;
            if (!inf_q) begin
               rep_cnt_q <= rep_cnt_q - 8'h01;
               if (rep_cnt_q == 8'h01) rep_on_q <= 1'b0;
            end
         end else begin
            o_tx_char <= bxf_pkg::SYN_C;
            o_tx_raw <= 1'b0;
         end
      end
   end
endmodule

// *** verif/bxf_framer_asserts.sv ***
// Port checker for bxf_framer: bus answer timing and holds, receive pulse, transmit pacing.
// Assumes it is bound to bxf_framer and sees only that module's ports.
`timescale 1ns/100ps
module bxf_framer_asserts (
   input wire logic       i_core_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_arvalid,
   input wire logic       i_rready,
   input wire logic       i_bready,
   input wire logic       i_tx_req,
   input wire logic       o_rvalid,
   input wire logic [31:0] o_rdata,
   input wire logic       o_bvalid,
   input wire logic [1:0] o_bresp,
   input wire logic [7:0] o_tx_char,
   input wire logic       o_c_lead,
   input wire logic       o_rx_valid
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   sequence rd_taken;
      i_arvalid && !o_rvalid;
   endsequence
   // Two quiet edges so the one-cycle update after a request has landed
   sequence tx_quiet;
      !i_tx_req ##1 !i_tx_req;
   endsequence
   rd_answer_a: assert property (rd_taken |=> o_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped early");
   wr_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");
   rd_done_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
      else $error("read answer repeated");
   wr_done_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write answer repeated");
   rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid [*6])
      else $error("receive pulse too long");
   tx_hold_a: assert property (tx_quiet |=> $stable(o_tx_char))
      else $error("tx char moved without request");
   lead_hold_a: assert property (tx_quiet |=> $stable(o_c_lead))
      else $error("C lead moved without request");
endmodule
bind bxf_framer bxf_framer_asserts bxf_framer_asserts_i (.i_core_clk, .i_sys_rst, .i_arvalid,
   .i_rready, .i_bready, .i_tx_req, .o_rvalid, .o_rdata, .o_bvalid, .o_bresp, .o_tx_char,
   .o_c_lead, .o_rx_valid);

// *** verif/bxf_line_model.sv ***
// Far-side line model: remote station handing characters in and pulling transmit characters.
// Assumes the framer samples characters a few clocks after the strobe rises.
`timescale 1ns/100ps
module bxf_line_model (
   input  wire logic       i_clk,
   output logic            o_stb,
   output logic [7:0]      o_char,
   output logic            o_cts_n,
   output logic            o_tx_req
);
   initial begin
      o_stb = 1'b0;
      o_char = 8'h00;
      o_cts_n = 1'b1;
      o_tx_req = 1'b0;
   end
   // Released line shows the inverse so a stale value can never look right
   task send(input logic [7:0] c);
      @(posedge i_clk) o_char <= c;
      repeat (4) @(posedge i_clk);
      o_stb <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_stb <= 1'b0;
      o_char <= ~c;
   endtask
   task pull;
      @(posedge i_clk) o_tx_req <= 1'b1;
      @(posedge i_clk) o_tx_req <= 1'b0;
   endtask
endmodule

// *** verif/tb.sv ***
// Testbench: register access, CRC and LRC framed receive, embedded transmit command.
// Assumes the line model stands on the serial side and the bench is the AXI master.
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic i_core_clk = 0, i_sys_rst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   logic i_arvalid = 0, i_rready = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic i_rx_stb, i_cts_n, i_tx_req, o_tx_raw, o_c_lead, o_rx_valid;
   logic [7:0] i_awaddr = 0, i_araddr = 0, i_rx_char, o_tx_char, o_rx_data;
   logic [31:0] i_wdata = 0, o_rdata, rv;
   logic [3:0] i_wstrb = 4'hf;
   logic [1:0] o_bresp, o_rresp, rs;
   logic [15:0] c;
   int n_errors = 0, checks = 0, n_rx = 0;
   logic [7:0] last_rx = 8'h00;
   always #25 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      if (o_rx_valid) begin
         n_rx <= n_rx + 1;
         last_rx <= o_rx_data;
      end
   end
   bxf_framer bxf_framer_i (.i_core_clk, .i_sys_rst, .i_awaddr, .i_awvalid, .o_awready,
      .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
      .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_rx_stb, .i_rx_char,
      .i_cts_n, .i_tx_req, .o_tx_char, .o_tx_raw, .o_c_lead, .o_rx_valid, .o_rx_data);
   bxf_line_model lm (.i_clk(i_core_clk), .o_stb(i_rx_stb), .o_char(i_rx_char),
      .o_cts_n(i_cts_n), .o_tx_req(i_tx_req));
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'b111};
      do begin
         @(posedge i_core_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (!o_bvalid);
      i_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge i_core_clk);
      {i_araddr, i_arvalid, i_rready} <= {a, 2'b11};
      do begin
         @(posedge i_core_clk);
         if (o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid);
      i_rready <= 1'b0;
      {rv, rs} = {o_rdata, o_rresp};
   endtask
   function automatic logic [15:0] crc(input logic [15:0] r, input logic [7:0] b);
      for (int i = 0; i < 8; i++) r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? 16'h8005 : 16'h0);
      return r;
   endfunction
   task frame(input logic [7:0] q[$], input logic [1:0] st);
      foreach (q[i]) lm.send(q[i]);
      repeat (8) @(posedge i_core_clk);
      rd(bxf_pkg::STAT_OFS);
      `CHK(rv[1:0], st)
      `CHK(last_rx, bxf_pkg::ETX_C)
   endtask
   task t_reset;
      rd(bxf_pkg::TERM_OFS);
      `CHK(rv[7:0], 8'h10)
      rd(8'h20);
      `CHK(rs, 2'b10)
   endtask
   // Embedded SYN between data must stay out of the check
   task t_crc;
      c = crc(crc(crc(16'h0, 8'h41), 8'h42), bxf_pkg::ETX_C);
      frame({bxf_pkg::SYN_C, bxf_pkg::SYN_C, bxf_pkg::STX_C, 8'h41, bxf_pkg::SYN_C, 8'h42,
         bxf_pkg::ETX_C, c[15:8], c[7:0]}, 2'b01);
      rd(bxf_pkg::STAT_OFS);
      `CHK(rv[1:0], 2'b00)
      frame({bxf_pkg::SYN_C, bxf_pkg::SYN_C, bxf_pkg::STX_C, 8'h41, 8'h42, bxf_pkg::ETX_C,
         c[15:8], ~c[7:0]}, 2'b11);
   endtask
   task t_lrc;
      wr(bxf_pkg::OPT2_OFS, 32'h80);
      frame({bxf_pkg::SYN_C, bxf_pkg::SYN_C, bxf_pkg::STX_C, 8'h41, 8'h44, bxf_pkg::ETX_C,
         8'h41 ^ 8'h44 ^ bxf_pkg::ETX_C, 8'h00}, 2'b01);
   endtask
   task t_etc;
      logic [31:0] cmd;
      wr(bxf_pkg::OPT2_OFS, 32'h20);
      cmd = 32'h80015502;
      for (int i = 0; i < 4; i++) begin
         wr(bxf_pkg::TXD_OFS, {24'h000000, cmd[31 - 8 * i -: 8]});
         lm.pull;
      end
      for (int k = 0; k < 3; k++) begin
         lm.pull;
         repeat (2) @(posedge i_core_clk);
         `CHK(o_tx_char, (k < 2) ? 8'h55 : bxf_pkg::SYN_C)
         `CHK(o_c_lead, 1'b1)
         `CHK(o_tx_raw, k < 2)
      end
   endtask
   // Steady SYN: event after the second one, third one stripped, no second report
   task t_x21;
      int n0;
      wr(bxf_pkg::OPT3_OFS, 32'h61);
      n0 = n_rx;
      lm.send(bxf_pkg::SYN_C);
      lm.send(bxf_pkg::SYN_C);
      rd(bxf_pkg::STAT_OFS);
      `CHK(rv[3], 1'b1)
      lm.send(bxf_pkg::SYN_C);
      repeat (4) @(posedge i_core_clk);
      `CHK(n_rx - n0, 2)
      rd(bxf_pkg::STAT_OFS);
      `CHK(rv[3], 1'b0)
   endtask
   task test_done;
      $display("n_errors=%0d checks=%0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      t_reset;
      t_crc;
      t_lrc;
      t_etc;
      t_x21;
      test_done;
   end
   // Whole run needs well under 5000 cycles
   initial begin
      repeat (20000) @(posedge i_core_clk);
      n_errors++;
      test_done;
   end
endmodule
